// ===== rtl/cic_pkg.sv
// cic_pkg: register indices, field positions and reset values of the
// core interrupt control block.
// assumes a 32-bit classic wishbone with byte addresses, one word per index.
package cic_pkg;

  // bus geometry
  localparam int CIC_ADR_W = 12;
  localparam int CIC_IDX_W = 10;

  // register indices (byte address is four times the index)
  localparam logic [CIC_IDX_W-1:0] CIC_IDX_TIMER = 10'h001;
  localparam logic [CIC_IDX_W-1:0] CIC_IDX_PORT = 10'h006;
  localparam logic [CIC_IDX_W-1:0] CIC_IDX_CTRL_LO = 10'h00B;
  localparam logic [CIC_IDX_W-1:0] CIC_IDX_CTRL_HI = 10'h08B;
  localparam logic [CIC_IDX_W-1:0] CIC_IDX_CFG = 10'h081;
  localparam logic [CIC_IDX_W-1:0] CIC_IDX_DIR = 10'h086;
  localparam logic [CIC_IDX_W-1:0] CIC_IDX_EVT_STATUS = 10'h040;
  localparam logic [CIC_IDX_W-1:0] CIC_IDX_EVT_ENABLE = 10'h041;
  localparam logic [CIC_IDX_W-1:0] CIC_IDX_EVT_CLEAR = 10'h042;

  // interrupt_control field positions
  localparam int CIC_GIE_BIT = 7;
  localparam int CIC_PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int CIC_TOIE_BIT = 5;
  localparam int CIC_EXIE_BIT = 4;
  localparam int CIC_PCIE_BIT = 3;
  localparam int CIC_TOF_BIT = 2;
  localparam int CIC_EXF_BIT = 1;
  localparam int CIC_PCF_BIT = 0;

  // configuration field positions
  localparam int CIC_CFG_RISING_BIT = 0;
  localparam int CIC_CFG_EXTSEL_BIT = 1;

  // event status / enable / clear layout
  localparam int CIC_EV_PC_BIT = 0;
  localparam int CIC_EV_EX_BIT = 1;
  localparam int CIC_EV_TO_BIT = 2;
  localparam int CIC_EV_W = 3;

  // reset values
  localparam logic [7:0] CIC_CTRL_RST = 8'h00;
  localparam logic [7:0] CIC_TIMER_RST = 8'h00;
  localparam logic [7:0] CIC_CFG_RST = 8'h03;
  localparam logic [3:0] CIC_DIR_RST = 4'hF;
  localparam logic [CIC_EV_W-1:0] CIC_EV_RST = 3'h0;
  localparam logic [7:0] CIC_TIMER_MAX = 8'hFF;

endpackage : cic_pkg

// ===== rtl/cic_core_interrupt_control.sv
// cic_core_interrupt_control: interrupt control register with flags for
// timer overflow, external pin and pin change, plus a small timer.
// assumes a classic wishbone master on clk_i and asynchronous pins.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module cic_core_interrupt_control
  import cic_pkg::*;
(
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic master_clear_n_i, // reset pin, low active
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [CIC_ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic ext_irq_pin_i, // lowest port pin
  input wire logic [3:0] change_detect_pins_i, // upper port pins
  input wire logic timer_tick_i, // timer count enable pulse
  input wire logic periph_irq_i, // peripheral request level
  output logic core_irq_o, // request to the core
  output logic wake_o, // wake from sleep
  output logic event_irq_o // sticky event interrupt
);

  // bus decode helper
  function automatic logic idx_hit(input logic [CIC_ADR_W-1:0] adr, input logic [CIC_IDX_W-1:0] idx);
    idx_hit = (adr[CIC_ADR_W-1:2] == idx);
  endfunction

  // state
  logic master_clear_n_sync1;
  logic master_clear_n_sync2;
  logic ext_sync1;
  logic ext_sync2;
  logic ext_prev;
  logic [3:0] chg_sync1;
  logic [3:0] chg_sync2;
  logic [3:0] port_latch;
  logic [7:0] interrupt_control;
  logic [7:0] timer_zero_count;
  logic [7:0] ext_config;
  logic [3:0] pin_is_input;
  logic [CIC_EV_W-1:0] evt_status;
  logic [CIC_EV_W-1:0] evt_enable;

  // master clear synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_clear_n_sync1 <= 1'b0;
      master_clear_n_sync2 <= 1'b0;
    end else begin
      master_clear_n_sync1 <= master_clear_n_i;
      master_clear_n_sync2 <= master_clear_n_sync1;
    end
  end

  // combined reset of the interrupt logic
  logic core_rst;
  assign core_rst = rst_i | ~master_clear_n_sync2;

  // pin synchronisers, free running through reset
  // so edge history and port latch hold the idle pin levels at release
  always_ff @(posedge clk_i) begin
    ext_sync1 <= ext_irq_pin_i;
    ext_sync2 <= ext_sync1;
    chg_sync1 <= change_detect_pins_i;
    chg_sync2 <= chg_sync1;
  end

  // bus request decode
  logic bus_req;
  logic wr_done;
  logic rd_done;
  logic wr_lane0;
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_done = bus_req & wb_we_i & wb_ack_o;
  assign rd_done = bus_req & ~wb_we_i & wb_ack_o;
  assign wr_lane0 = wr_done & wb_sel_i[0];

  logic hit_ctrl;
  logic hit_port;
  logic hit_timer;
  logic hit_cfg;
  logic hit_dir;
  logic hit_status;
  logic hit_enable;
  logic hit_clear;
  assign hit_ctrl = idx_hit(wb_adr_i, CIC_IDX_CTRL_LO) | idx_hit(wb_adr_i, CIC_IDX_CTRL_HI);
  assign hit_port = idx_hit(wb_adr_i, CIC_IDX_PORT);
  assign hit_timer = idx_hit(wb_adr_i, CIC_IDX_TIMER);
  assign hit_cfg = idx_hit(wb_adr_i, CIC_IDX_CFG);
  assign hit_dir = idx_hit(wb_adr_i, CIC_IDX_DIR);
  assign hit_status = idx_hit(wb_adr_i, CIC_IDX_EVT_STATUS);
  assign hit_enable = idx_hit(wb_adr_i, CIC_IDX_EVT_ENABLE);
  assign hit_clear = idx_hit(wb_adr_i, CIC_IDX_EVT_CLEAR);

  // write strobes per register
  logic wr_ctrl;
  logic wr_timer;
  logic wr_cfg;
  logic wr_dir;
  logic wr_enable;
  logic wr_clear;
  logic port_access;
  assign wr_ctrl = wr_lane0 & hit_ctrl;
  assign wr_timer = wr_lane0 & hit_timer;
  assign wr_cfg = wr_lane0 & hit_cfg;
  assign wr_dir = wr_lane0 & hit_dir;
  assign wr_enable = wr_lane0 & hit_enable;
  assign wr_clear = wr_lane0 & hit_clear;
  assign port_access = (rd_done | wr_done) & hit_port;

  // named fields of the control register
  logic global_irq_enable;
  logic peripheral_irq_enable;
  logic timer_overflow_irq_enable;
  logic ext_pin_irq_enable;
  logic pin_change_irq_enable;
  logic timer_overflow_flag;
  logic ext_pin_irq_flag;
  logic pin_change_flag;
  assign global_irq_enable = interrupt_control[CIC_GIE_BIT];
  assign peripheral_irq_enable = interrupt_control[CIC_PERIPHERAL_IRQ_ENABLE_BIT];
  assign timer_overflow_irq_enable = interrupt_control[CIC_TOIE_BIT];
  assign ext_pin_irq_enable = interrupt_control[CIC_EXIE_BIT];
  assign pin_change_irq_enable = interrupt_control[CIC_PCIE_BIT];
  assign timer_overflow_flag = interrupt_control[CIC_TOF_BIT];
  assign ext_pin_irq_flag = interrupt_control[CIC_EXF_BIT];
  assign pin_change_flag = interrupt_control[CIC_PCF_BIT];

  // source conditions
  logic timer_wrap;
  logic ext_edge;
  logic [3:0] mismatch_bits;
  logic pin_mismatch;
  assign timer_wrap = timer_tick_i & ~wr_timer & (timer_zero_count == CIC_TIMER_MAX);
  assign ext_edge = ext_config[CIC_CFG_EXTSEL_BIT] &
                    (ext_config[CIC_CFG_RISING_BIT] ? (ext_sync2 & ~ext_prev) : (~ext_sync2 & ext_prev));
  assign mismatch_bits = pin_is_input & (chg_sync2 ^ port_latch);
  assign pin_mismatch = |mismatch_bits;

  // flag set vector in control register order
  logic [2:0] flag_set;
  assign flag_set = {timer_wrap, ext_edge, pin_mismatch};

  // next control register: software value, then hardware sets win
  logic [7:0] ctrl_base;
  logic [7:0] next_interrupt_control;
  assign ctrl_base = wr_ctrl ? wb_dat_i[7:0] : interrupt_control;
  assign next_interrupt_control = {ctrl_base[7:3], ctrl_base[2:0] | flag_set};

  // control register
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      interrupt_control <= CIC_CTRL_RST;
    end else begin
      interrupt_control <= next_interrupt_control;
    end
  end

  // timer count
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      timer_zero_count <= CIC_TIMER_RST;
    end else if (wr_timer) begin
      timer_zero_count <= wb_dat_i[7:0];
    end else if (timer_tick_i) begin
      timer_zero_count <= timer_zero_count + 8'h01; // wraps to zero
    end
  end

  // configuration and direction
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      ext_config <= CIC_CFG_RST;
      pin_is_input <= CIC_DIR_RST;
    end else begin
      if (wr_cfg) begin
        ext_config <= {6'h00, wb_dat_i[1:0]};
      end
      if (wr_dir) begin
        pin_is_input <= wb_dat_i[3:0];
      end
    end
  end

  // edge history and port latch track the pins during reset
  always_ff @(posedge clk_i) begin
    ext_prev <= ext_sync2;
    if (core_rst || port_access) begin
      port_latch <= chg_sync2;
    end
  end

  // sticky event status, set beats clear
  logic [CIC_EV_W-1:0] evt_set;
  logic [CIC_EV_W-1:0] evt_clr;
  assign evt_set = {timer_wrap, ext_edge, pin_mismatch};
  assign evt_clr = wr_clear ? wb_dat_i[CIC_EV_W-1:0] : CIC_EV_RST;

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      evt_status <= CIC_EV_RST;
      evt_enable <= CIC_EV_RST;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
      if (wr_enable) begin
        evt_enable <= wb_dat_i[CIC_EV_W-1:0];
      end
    end
  end

  // read data selection
  logic [7:0] port_value;
  logic [7:0] rdata;
  assign port_value = {chg_sync2, 3'h0, ext_sync2};
  assign rdata = hit_ctrl ? interrupt_control :
                 hit_port ? port_value :
                 hit_timer ? timer_zero_count :
                 hit_cfg ? ext_config :
                 hit_dir ? {4'h0, pin_is_input} :
                 hit_status ? {5'h00, evt_status} :
                 hit_enable ? {5'h00, evt_enable} :
                 8'h00;

  // wishbone answer one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= {24'h00_0000, rdata};
      end
    end
  end

  // interrupt outputs
  logic src_pending;
  assign src_pending = (timer_overflow_irq_enable & timer_overflow_flag) |
                       (ext_pin_irq_enable & ext_pin_irq_flag) |
                       (pin_change_irq_enable & pin_change_flag) |
                       (peripheral_irq_enable & periph_irq_i);
  assign core_irq_o = global_irq_enable & src_pending;
  assign wake_o = pin_change_irq_enable & pin_change_flag;
  assign event_irq_o = |(evt_status & evt_enable);

  // checks
  default clocking cic_cb @(posedge clk_i);
  endclocking
  default disable iff (core_rst);

  chk_timer_flag_set: assert property (
    timer_wrap |=> timer_overflow_flag && (timer_zero_count == 8'h00)
  ) else $error("timer wrap did not set its flag");

  chk_ext_flag_set: assert property (
    (ext_edge && !ext_pin_irq_enable) |=> ext_pin_irq_flag
  ) else $error("external edge did not set its flag");

  chk_ext_flag_sticky: assert property (
    (ext_pin_irq_flag && !wr_ctrl) |=> ext_pin_irq_flag
  ) else $error("external flag dropped without software");

  chk_mismatch_resets: assert property (
    (pin_mismatch && wr_ctrl && !wb_dat_i[0]) |=> pin_change_flag
  ) else $error("clear won over a standing mismatch");

  chk_change_flag_set: assert property (
    ($changed(chg_sync2) && !port_access && ((pin_is_input & (chg_sync2 ^ $past(chg_sync2))) != 4'h0)
      && ($past(port_latch) == $past(chg_sync2)) && (port_latch == $past(chg_sync2))) |=> pin_change_flag
  ) else $error("input pin change missed");

  chk_output_excluded: assert property (
    (pin_is_input == 4'h0) |-> !pin_mismatch
  ) else $error("output pin raised a mismatch");

  chk_global_block: assert property (
    !global_irq_enable |-> !core_irq_o
  ) else $error("request with global enable clear");

  chk_enabled_request: assert property (
    (global_irq_enable && timer_overflow_irq_enable && timer_overflow_flag) |-> core_irq_o
  ) else $error("enabled flag gave no request");

  chk_alias_write: assert property (
    (wr_ctrl && idx_hit(wb_adr_i, CIC_IDX_CTRL_HI)) |=> (interrupt_control[7:3] == $past(wb_dat_i[7:3]))
  ) else $error("upper alias write not stored");

  chk_wake_level: assert property (
    (pin_change_flag && pin_change_irq_enable && !global_irq_enable) |-> wake_o
  ) else $error("pin change gave no wake");

  chk_clear_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (!master_clear_n_sync2) |=> (interrupt_control == 8'h00) && (evt_status == 3'h0)
  ) else $error("master clear did not reset");

  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held two cycles");

  chk_evt_set_wins: assert property (
    (evt_set != CIC_EV_RST) |=> ((evt_status & $past(evt_set)) == $past(evt_set))
  ) else $error("event status missed a set");

  chk_pc_flag_set: assert property (
    pin_mismatch |=> pin_change_flag
  ) else $error("standing mismatch did not set the flag");

  chk_port_latch_load: assert property (
    port_access |=> (port_latch == $past(chg_sync2))
  ) else $error("port access did not reload the latch");

  chk_ext_deselect: assert property (
    (!ext_config[CIC_CFG_EXTSEL_BIT] && !wr_ctrl && !ext_pin_irq_flag) |=> !ext_pin_irq_flag
  ) else $error("deselected pin set the external flag");

  chk_timer_count: assert property (
    (timer_tick_i && !wr_timer) |=> (timer_zero_count == $past(timer_zero_count) + 8'h01)
  ) else $error("timer did not step on its tick");

endmodule // cic_core_interrupt_control

`default_nettype wire

// ===== verification/cic_core_model.sv
// cic_core_model: stand-in for the processor core that services requests.
// assumes the request is a level from the block, sampled on clk_i.
`timescale 1ns/1ns
`default_nettype none

module cic_core_model
  import cic_pkg::*;
(
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic core_irq_i, // request from the block
  output logic [7:0] taken_o // requests taken so far
);
  logic irq_q;

  // the core takes a request once per rising level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      taken_o <= 8'h00;
    end else begin
      irq_q <= core_irq_i;
      if (core_irq_i && !irq_q) begin
        taken_o <= taken_o + 8'h01;
      end
    end
  end
endmodule // cic_core_model

`default_nettype wire

// ===== verification/cic_core_interrupt_control_test.sv
// cic_core_interrupt_control_test: register and event tests of the block.
// assumes the design package and the core model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module cic_core_interrupt_control_test
  import cic_pkg::*;
;
  logic clk_i, rst_i, master_clear_n_n, cyc, stb, we, ext, tick, periph;
  logic [11:0] adr;
  logic [3:0] pins;
  logic [31:0] dat, rdat;
  logic ack, irq, wake, evt;
  logic [7:0] taken, q;
  int err_total, cmp_count, cyc_n;

  cic_core_interrupt_control cic_core_interrupt_control_i (
    .clk_i(clk_i), .rst_i(rst_i), .master_clear_n_i(master_clear_n_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_irq_pin_i(ext), .change_detect_pins_i(pins),
    .timer_tick_i(tick), .periph_irq_i(periph),
    .core_irq_o(irq), .wake_o(wake), .event_irq_o(evt));

  cic_core_model cic_core_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .core_irq_i(irq), .taken_o(taken));

  // clock and cycle ceiling
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // main sequence
  initial begin
    {cyc, stb, we, ext, tick, periph} = 6'h00;
    adr = 12'h000;
    dat = 32'h00000000;
    pins = 4'h0;
    master_clear_n_n = 1'b1;
    rst_i = 1'b1;
    wait_n(6);
    rst_i <= 1'b0;
    wait_n(4);
    rd(12'h02C, CIC_CTRL_RST, "ctrl_lo");
    rd(12'h22C, CIC_CTRL_RST, "ctrl_hi");
    rd(12'h204, CIC_CFG_RST, "cfg");
    rd(12'h218, 8'h0F, "dir");
    rd(12'h004, CIC_TIMER_RST, "timer");
    rd(12'h3FC, 8'h00, "unmapped");
    // external pin flag with every enable off
    ext <= 1'b1;
    wait_n(6);
    rd(12'h02C, 8'h02, "ext_flag");
    chk("irq_gie_off", irq, 1'b0);
    wr(12'h02C, 8'h92);
    wait_n(1);
    chk("irq_ext", irq, 1'b1);
    wr(12'h22C, 8'h90);
    rd(12'h02C, 8'h90, "ext_clear");
    // pin change: clear refused until port read
    pins <= 4'h1;
    wait_n(6);
    rd(12'h02C, 8'h91, "pc_flag");
    wr(12'h02C, 8'h98);
    rd(12'h02C, 8'h99, "pc_reset");
    chk("wake", wake, 1'b1);
    rd(12'h018, 8'h11, "port");
    wr(12'h02C, 8'h98);
    rd(12'h02C, 8'h98, "pc_clear");
    // output pin takes no part
    wr(12'h218, 8'h0E);
    pins <= 4'h0;
    wait_n(6);
    rd(12'h02C, 8'h98, "pc_output");
    // timer wrap
    wr(12'h02C, 8'h00);
    wr(12'h004, CIC_TIMER_MAX);
    @(posedge clk_i) tick <= 1'b1;
    @(posedge clk_i) tick <= 1'b0;
    wait_n(2);
    rd(12'h004, 8'h00, "timer_wrap");
    rd(12'h02C, 8'h04, "timer_flag");
    // peripheral request with its enable set, gated by global enable
    wr(12'h02C, 8'hC0);
    periph <= 1'b1;
    wait_n(2);
    chk("irq_periph", irq, 1'b1);
    wr(12'h02C, 8'h40);
    wait_n(1);
    chk("irq_blocked", irq, 1'b0);
    periph <= 1'b0;
    chk("taken", taken, 8'h03);
    // sticky event status, enable mask and clear
    rd(12'h100, 8'h07, "evt_status");
    chk("evt_off", evt, 1'b0);
    wr(12'h104, 8'h07);
    wait_n(1);
    chk("evt_on", evt, 1'b1);
    wr(12'h100, 8'h00);
    rd(12'h100, 8'h07, "evt_ro");
    wr(12'h108, 8'h07);
    rd(12'h108, 8'h00, "evt_clr");
    rd(12'h100, 8'h00, "evt_cleared");
    wait_n(1);
    chk("evt_low", evt, 1'b0);
    // external pin deselected, then falling edge mode
    wr(12'h204, 8'h00);
    ext <= 1'b0;
    wait_n(6);
    rd(12'h02C, 8'h40, "ext_off");
    wr(12'h204, 8'h02);
    ext <= 1'b1;
    wait_n(6);
    rd(12'h02C, 8'h40, "ext_rise_ign");
    ext <= 1'b0;
    wait_n(6);
    rd(12'h02C, 8'h42, "ext_fall");
    // master clear pin
    wr(12'h02C, 8'hF8);
    master_clear_n_n <= 1'b0;
    wait_n(5);
    master_clear_n_n <= 1'b1;
    wait_n(5);
    rd(12'h22C, 8'h00, "master_clear_n");
    give_verdict();
  end
endmodule // cic_core_interrupt_control_test

`default_nettype wire
